// file: hdl/ivp_irq_arbiter.sv
// interrupt arbiter and vector generator with avalon register slave
// Notes on behaviour
// - registers reached as a bus slave; priorities written by software.
// - each programmable source takes one of four levels; two sources fixed.
// - within a level the lowest active source number wins.
// - request the core when a serviceable request exists, with its address.
// - normal address is vector base concatenated with vector number.
// - level code: 00 none, 01 level 0, 10 level 1, 11 level 2 or 3.
// - a request preempts only when the core mask is 00 or its level is at least the mask.
// - two fast channels, each with match, low and high address registers.
// - fast only on a match with either channel and level 2.
// - fast match supplies channel address instead of base plus number.
// - fast recognition done here, flagged to the core with the vector.
// - pending irq in wait or stop raises a wake to the system unit.
// - after reset the initial fetch address is driven onto the address bus.
// - in low power only sources enabled before entry may wake.
// - in low power both external pins act low-level sensitive.
`timescale 1ns/1ps
`include "ivp_params.svh"

module ivp_irq_arbiter
    import ivp_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic [7:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [`IVP_NUM_SRC-1:0]   periphIrq,
    input  wire logic                      externalIrqA_n,
    input  wire logic                      externalIrqB_n,
    input  wire logic [1:0]                coreStatusMask,
    input  wire logic                      coreIrqAck,
    input  wire logic                      lowPowerMode,
    output ivp_core_req_s                  coreReq,
    output logic                           coreAddrDrive,
    output logic                           wakeRequest
);

    // ********************************
    // functions
    // ********************************

    // lowest set bit, with found flag in the top bit
    function automatic logic [7:0] lowest_set(input logic [`IVP_NUM_SRC-1:0] v);
        logic [7:0] res;
        res = 8'h00;
        for (int s = `IVP_NUM_SRC - 1; s >= 0; s--) begin
            if (v[s]) res = {1'b1, 7'(s)};
        end
        return res;
    endfunction : lowest_set

    // a level passes a code when code is 00 or the level is at least the code
    function automatic logic level_passes(input logic [1:0] code, input logic [1:0] lvl);
        return (code == 2'h0) || (lvl >= code);
    endfunction : level_passes

    // level of a source to the two-bit report code
    function automatic logic [1:0] level_code(input logic [1:0] lvl);
        return (lvl >= 2'h2) ? 2'h3 : 2'(lvl + 2'h1);
    endfunction : level_code

    // ********************************
    // register state
    // ********************************
    ivp_phase_e                phase_reg;
    logic [31:0]               rdData_reg;
    ivp_word_t                 vbase_reg;
    ivp_vec_t                  fastMatch_reg [2];
    ivp_word_t                 fastLow_reg   [2];
    ivp_word_t                 fastHigh_reg  [2];
    ivp_word_t                 enable_reg    [`IVP_EN_WORDS];
    logic [1:0]                edgeSel_reg;
    logic [`IVP_NUM_SRC-1:0]   enSnap_reg;
    logic                      lowPowerDly_reg;
    logic [1:0]                pinMeta_reg;
    logic [1:0]                pinSync_reg;
    logic [1:0]                pinPrev_reg;
    logic [1:0]                edgeHeld_reg;
    logic                      bootDrive_reg;

    logic [7:0]                regIdx;
    logic                      aligned;
    logic                      busReq;
    logic                      wrStrobe;
    ivp_word_t                 wrWord;
    ivp_word_t                 prioRd;
    logic [159:0]              prioFlat;
    logic [95:0]               enableFlat;
    logic [`IVP_NUM_SRC-1:0]   rawReq;
    logic [`IVP_NUM_SRC-1:0]   activeReq;
    logic [1:0]                srcLevel [`IVP_NUM_SRC];
    logic [7:0]                levelWin [`IVP_NUM_LEVELS];
    logic                      winValid;
    logic [1:0]                winLevel;
    ivp_vec_t                  winVec;
    logic [1:0]                fastHit;
    ivp_core_req_s             reqNext;

    // ********************************
    // register bus slave
    // ********************************
    assign regIdx   = {2'b00, avs_address[7:2]};
    assign aligned  = (avs_address[1:0] == 2'b00);
    assign busReq   = avs_read || avs_write;
    assign wrStrobe = avs_write && (phase_reg == IVP_PH_ANSWER);
    assign wrWord   = avs_writedata[15:0];

    // fixed wait: fetch the word, latch it, then answer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase_reg <= IVP_PH_IDLE;
        end else begin
            unique case (phase_reg)
                IVP_PH_IDLE:   phase_reg <= busReq ? IVP_PH_FETCH : IVP_PH_IDLE;
                IVP_PH_FETCH:  phase_reg <= IVP_PH_ANSWER;
                IVP_PH_ANSWER: phase_reg <= IVP_PH_IDLE;
                default:       phase_reg <= IVP_PH_IDLE;
            endcase
        end
    end

    assign avs_waitrequest = busReq && (phase_reg != IVP_PH_ANSWER);
    assign avs_readdata    = rdData_reg;

    ivp_prio_store u_prio (
        .core_clk   (core_clk),
        .reset      (reset),
        .wrEn       (wrStrobe && aligned && (regIdx <= `IVP_IDX_PRIO_LAST)),
        .wrIdx      (regIdx[3:0]),
        .wrLanes    (avs_byteenable[1:0]),
        .wrData     (wrWord),
        .rdIdx      (regIdx[3:0]),
        .rdData     (prioRd),
        .fieldsFlat (prioFlat)
    );

    // read mux latched in the fetch phase; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdData_reg <= 32'h00000000;
        end else if (phase_reg == IVP_PH_FETCH) begin
            rdData_reg <= 32'h00000000;
            if (avs_read && aligned) begin
                if (regIdx <= `IVP_IDX_PRIO_LAST) begin
                    rdData_reg[15:0] <= prioRd;
                end else if (regIdx == `IVP_IDX_VBASE) begin
                    rdData_reg[15:0] <= vbase_reg;
                end else if (regIdx == `IVP_IDX_FM0) begin
                    rdData_reg[6:0] <= fastMatch_reg[0];
                end else if (regIdx == `IVP_IDX_FVL0) begin
                    rdData_reg[15:0] <= fastLow_reg[0];
                end else if (regIdx == `IVP_IDX_FVH0) begin
                    rdData_reg[15:0] <= fastHigh_reg[0];
                end else if (regIdx == `IVP_IDX_FM1) begin
                    rdData_reg[6:0] <= fastMatch_reg[1];
                end else if (regIdx == `IVP_IDX_FVL1) begin
                    rdData_reg[15:0] <= fastLow_reg[1];
                end else if (regIdx == `IVP_IDX_FVH1) begin
                    rdData_reg[15:0] <= fastHigh_reg[1];
                end else if (regIdx <= `IVP_IDX_PEND_LAST) begin
                    rdData_reg[15:0] <=
                        16'({14'h0000, rawReq} >> ((regIdx - `IVP_IDX_PEND_FIRST) * 16));
                end else if (regIdx <= `IVP_IDX_EN_LAST) begin
                    rdData_reg[15:0] <= enable_reg[3'(regIdx - `IVP_IDX_EN_FIRST)];
                end else if (regIdx == `IVP_IDX_CTRL) begin
                    rdData_reg[`IVP_CTRL_EDGE_B:`IVP_CTRL_EDGE_A] <= edgeSel_reg;
                    rdData_reg[`IVP_CTRL_REQ] <= coreReq.request;
                    rdData_reg[`IVP_CTRL_LVL_HI:`IVP_CTRL_LVL_LO] <= coreReq.levelCode;
                    rdData_reg[`IVP_CTRL_WAKE] <= wakeRequest;
                end
            end
        end
    end

    // vector base, fast channels, enables and control
    always_ff @(posedge core_clk) begin
        if (reset) begin
            vbase_reg   <= `IVP_REG_RESET;
            edgeSel_reg <= 2'b00;
            for (int c = 0; c < 2; c++) begin
                fastMatch_reg[c] <= 7'h00;
                fastLow_reg[c]   <= `IVP_REG_RESET;
                fastHigh_reg[c]  <= `IVP_REG_RESET;
            end
            for (int e = 0; e < `IVP_EN_WORDS; e++) begin
                enable_reg[e] <= `IVP_REG_RESET;
            end
        end else if (wrStrobe && aligned && avs_byteenable[0]) begin
            unique case (regIdx)
                `IVP_IDX_VBASE: vbase_reg        <= wrWord;
                `IVP_IDX_FM0:   fastMatch_reg[0] <= wrWord[6:0];
                `IVP_IDX_FVL0:  fastLow_reg[0]   <= wrWord;
                `IVP_IDX_FVH0:  fastHigh_reg[0]  <= wrWord;
                `IVP_IDX_FM1:   fastMatch_reg[1] <= wrWord[6:0];
                `IVP_IDX_FVL1:  fastLow_reg[1]   <= wrWord;
                `IVP_IDX_FVH1:  fastHigh_reg[1]  <= wrWord;
                `IVP_IDX_CTRL:  edgeSel_reg      <= wrWord[1:0];
                default: begin
                    if (regIdx >= `IVP_IDX_EN_FIRST && regIdx <= `IVP_IDX_EN_LAST) begin
                        enable_reg[3'(regIdx - `IVP_IDX_EN_FIRST)] <= wrWord;
                    end
                end
            endcase
        end
    end

    // ********************************
    // request conditioning
    // ********************************

    // external pins pass two flops before anything looks at them
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinMeta_reg <= 2'b11;
            pinSync_reg <= 2'b11;
            pinPrev_reg <= 2'b11;
        end else begin
            pinMeta_reg <= {externalIrqB_n, externalIrqA_n};
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
        end
    end

    // falling-edge capture; a new edge beats an acknowledge in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            edgeHeld_reg <= 2'b00;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (pinPrev_reg[p] && !pinSync_reg[p]) begin
                    edgeHeld_reg[p] <= 1'b1;
                end else if (coreIrqAck && coreReq.request &&
                             coreReq.vecNum == 7'(`IVP_EXT_A_SRC + p)) begin
                    edgeHeld_reg[p] <= 1'b0;
                end
            end
        end
    end

    // enable snapshot taken as low power is entered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lowPowerDly_reg <= 1'b0;
            enSnap_reg      <= '0;
        end else begin
            lowPowerDly_reg <= lowPowerMode;
            if (lowPowerMode && !lowPowerDly_reg) begin
                enSnap_reg <= enableFlat[`IVP_NUM_SRC-1:0];
            end
        end
    end

    always_comb begin
        for (int e = 0; e < `IVP_EN_WORDS; e++) begin
            enableFlat[e*16 +: 16] = enable_reg[e];
        end
        // fixed sources cannot be disabled
        enableFlat[`IVP_NUM_FIXED-1:0] = '1;
        rawReq = periphIrq;
        for (int p = 0; p < 2; p++) begin
            // no clock to see an edge while asleep, so level mode there
            if (lowPowerMode || !edgeSel_reg[p]) begin
                rawReq[`IVP_EXT_A_SRC + p] = !pinSync_reg[p];
            end else begin
                rawReq[`IVP_EXT_A_SRC + p] = edgeHeld_reg[p];
            end
        end
        // after entry, only what was enabled beforehand counts
        activeReq = rawReq & ((lowPowerMode && lowPowerDly_reg) ?
                              enSnap_reg : enableFlat[`IVP_NUM_SRC-1:0]);
    end

    assign wakeRequest = lowPowerMode && lowPowerDly_reg && (|(rawReq & enSnap_reg));

    // ********************************
    // arbitration
    // ********************************
    always_comb begin
        for (int s = 0; s < `IVP_NUM_SRC; s++) begin
            if (s < `IVP_NUM_FIXED) begin
                srcLevel[s] = `IVP_FIXED_LEVEL;
            end else begin
                srcLevel[s] = prioFlat[(s - `IVP_NUM_FIXED) * 2 +: 2];
            end
        end
        for (int l = 0; l < `IVP_NUM_LEVELS; l++) begin
            logic [`IVP_NUM_SRC-1:0] atLevel;
            atLevel = '0;
            for (int s = 0; s < `IVP_NUM_SRC; s++) begin
                atLevel[s] = activeReq[s] && (srcLevel[s] == 2'(l));
            end
            levelWin[l] = lowest_set(atLevel);
        end
        winValid = 1'b0;
        winLevel = 2'h0;
        winVec   = 7'h00;
        // highest level first; the core mask reflects the level in service
        for (int l = 0; l < `IVP_NUM_LEVELS; l++) begin
            if (levelWin[l][7] && level_passes(coreStatusMask, 2'(l))) begin
                winValid = 1'b1;
                winLevel = 2'(l);
                winVec   = levelWin[l][6:0];
            end
        end
        for (int c = 0; c < 2; c++) begin
            fastHit[c] = (winVec == fastMatch_reg[c]) && (winLevel == `IVP_FAST_LEVEL);
        end
        reqNext.request   = winValid;
        reqNext.levelCode = winValid ? level_code(winLevel) : 2'h0;
        reqNext.fast      = winValid && (|fastHit);
        reqNext.vecNum    = winVec;
        // channel zero wins if both channels name the same vector
        if (fastHit[0]) begin
            reqNext.vecAddr = {fastHigh_reg[0][`IVP_FVH_BITS-1:0], fastLow_reg[0]};
        end else if (fastHit[1]) begin
            reqNext.vecAddr = {fastHigh_reg[1][`IVP_FVH_BITS-1:0], fastLow_reg[1]};
        end else begin
            reqNext.vecAddr = {vbase_reg[`IVP_VBASE_BITS-1:0], winVec};
        end
        if (!winValid) begin
            reqNext.vecAddr = `IVP_RESET_ADDR;
        end
    end

    // core-facing outputs registered; reset shows the boot fetch address
    always_ff @(posedge core_clk) begin
        if (reset) begin
            coreReq         <= '0;
            coreReq.vecAddr <= `IVP_RESET_ADDR;
            bootDrive_reg   <= 1'b1;
        end else begin
            coreReq       <= reqNext;
            bootDrive_reg <= 1'b0;
        end
    end

    // address bus driven for the boot fetch and whenever a vector is offered
    assign coreAddrDrive = bootDrive_reg || coreReq.request;

endmodule : ivp_irq_arbiter

// file: common/ivp_params.svh
// constants for the priority interrupt vectoring unit
`ifndef IVP_PARAMS_SVH
`define IVP_PARAMS_SVH

// ********************************
// source and level geometry
// ********************************
`define IVP_NUM_SRC        82
`define IVP_NUM_FIXED      2
`define IVP_NUM_LEVELS     4
`define IVP_FAST_LEVEL     2'h2
`define IVP_FIXED_LEVEL    2'h3
`define IVP_EXT_A_SRC      2
`define IVP_EXT_B_SRC      3
`define IVP_PRIO_WORDS     10
`define IVP_EN_WORDS       6

// ********************************
// register indices (byte address is four times the index)
// ********************************
`define IVP_IDX_PRIO_FIRST 8'h00
`define IVP_IDX_PRIO_LAST  8'h09
`define IVP_IDX_VBASE      8'h0a
`define IVP_IDX_FM0        8'h0b
`define IVP_IDX_FVL0       8'h0c
`define IVP_IDX_FVH0       8'h0d
`define IVP_IDX_FM1        8'h0e
`define IVP_IDX_FVL1       8'h0f
`define IVP_IDX_FVH1       8'h10
`define IVP_IDX_PEND_FIRST 8'h11
`define IVP_IDX_PEND_LAST  8'h16
`define IVP_IDX_EN_FIRST   8'h17
`define IVP_IDX_EN_LAST    8'h1c
`define IVP_IDX_CTRL       8'h1d

// ********************************
// control register fields and reset values
// ********************************
`define IVP_CTRL_EDGE_A    0
`define IVP_CTRL_EDGE_B    1
`define IVP_CTRL_REQ       2
`define IVP_CTRL_LVL_LO    3
`define IVP_CTRL_LVL_HI    4
`define IVP_CTRL_WAKE      5
`define IVP_RESET_ADDR     21'h000000
`define IVP_REG_RESET      16'h0000
`define IVP_VBASE_BITS     14
`define IVP_FVH_BITS       5

`endif

// file: common/ivp_pkg.sv
// types shared by the priority interrupt vectoring unit
package ivp_pkg;

    typedef logic [6:0]  ivp_vec_t;
    typedef logic [20:0] ivp_addr_t;
    typedef logic [15:0] ivp_word_t;

    // register bus answer sequence
    typedef enum logic [1:0] {
        IVP_PH_IDLE   = 2'b00,
        IVP_PH_FETCH  = 2'b01,
        IVP_PH_ANSWER = 2'b10
    } ivp_phase_e;

    // everything the core sees about the winning request
    typedef struct packed {
        logic      request;
        logic [1:0] levelCode;
        logic      fast;
        ivp_vec_t  vecNum;
        ivp_addr_t vecAddr;
    } ivp_core_req_s;

endpackage : ivp_pkg

// file: hdl/ivp_prio_store.sv
// priority field storage with registered read port and flat level view
`timescale 1ns/1ps
`include "ivp_params.svh"

module ivp_prio_store
    import ivp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        wrEn,
    input  wire logic [3:0]  wrIdx,
    input  wire logic [1:0]  wrLanes,
    input  wire ivp_word_t   wrData,
    input  wire logic [3:0]  rdIdx,
    output ivp_word_t        rdData,
    output logic [159:0]     fieldsFlat
);

    ivp_word_t mem_reg [`IVP_PRIO_WORDS];

    // byte-lane write into the field words
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < `IVP_PRIO_WORDS; i++) begin
                mem_reg[i] <= `IVP_REG_RESET;
            end
        end else if (wrEn && (wrIdx < 4'(`IVP_PRIO_WORDS))) begin
            if (wrLanes[0]) mem_reg[wrIdx][7:0]  <= wrData[7:0];
            if (wrLanes[1]) mem_reg[wrIdx][15:8] <= wrData[15:8];
        end
    end

    // read data held in a register; out-of-range words read zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdData <= `IVP_REG_RESET;
        end else if (rdIdx < 4'(`IVP_PRIO_WORDS)) begin
            rdData <= mem_reg[rdIdx];
        end else begin
            rdData <= `IVP_REG_RESET;
        end
    end

    // arbitration needs every field at once
    always_comb begin
        for (int i = 0; i < `IVP_PRIO_WORDS; i++) begin
            fieldsFlat[i*16 +: 16] = mem_reg[i];
        end
    end

endmodule : ivp_prio_store

// file: tb/ivp_arb_chk.sv
// port assertions for the vectoring unit
`timescale 1ns/1ps
module ivp_arb_chk
    import ivp_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          reset,
    input wire logic          avs_read,
    input wire logic          avs_write,
    input wire logic [31:0]   avs_readdata,
    input wire logic          avs_waitrequest,
    input wire logic [1:0]    coreStatusMask,
    input wire logic          lowPowerMode,
    input wire ivp_core_req_s coreReq,
    input wire logic          coreAddrDrive,
    input wire logic          wakeRequest
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // two wait cycles per request
    property p_wait_two; $rose(avs_read || avs_write) |->
        avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_wait_two: assert property (p_wait_two) else $error("bus timing");
    property p_rd_stand; avs_read && !avs_waitrequest |=> $stable(avs_readdata); endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
    property p_code; coreReq.request |-> coreReq.levelCode != 2'h0; endproperty
    a_code: assert property (p_code) else $error("code 00");
    property p_idle; !coreReq.request |->
        coreReq.levelCode == 2'h0 && !coreReq.fast && coreReq.vecAddr == '0; endproperty
    a_idle: assert property (p_idle) else $error("idle fields");
    // mask of one cycle earlier
    property p_mask; coreReq.request |-> coreReq.levelCode == 2'h3
        || (coreReq.levelCode - 2'h1 >= $past(coreStatusMask)); endproperty
    a_mask: assert property (p_mask) else $error("masked level offered");
    property p_fast; coreReq.fast |-> coreReq.request && coreReq.levelCode == 2'h3; endproperty
    a_fast: assert property (p_fast) else $error("fast flag off level 2");
    property p_norm; coreReq.request && !coreReq.fast |->
        coreReq.vecAddr[6:0] == coreReq.vecNum; endproperty
    a_norm: assert property (p_norm) else $error("normal address");
    property p_drive; !$past(reset) |-> coreAddrDrive == coreReq.request; endproperty
    a_drive: assert property (p_drive) else $error("address drive mismatch");
    property p_rst; disable iff (1'b0) $past(reset) |->
        coreAddrDrive && coreReq.vecAddr == '0; endproperty
    a_rst: assert property (p_rst) else $error("reset address not driven");
    property p_wake; wakeRequest |-> lowPowerMode; endproperty
    a_wake: assert property (p_wake) else $error("wake outside low power");
endmodule : ivp_arb_chk

bind ivp_irq_arbiter ivp_arb_chk ivp_arb_chk_inst (.*);

// file: tb/ivp_core_model.sv
// core exception model for the vectoring unit
`timescale 1ns/1ps
module ivp_core_model
    import ivp_pkg::*;
#(
    parameter logic [15:0] SUBR_JUMP_OP = 16'h5a3c, // arbitrary opcode value
    parameter logic [15:0] FETCH_WORD   = 16'h0001
)
(
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  wire ivp_core_req_s coreReq,
    input  wire logic          slowAck,
    output logic               coreIrqAck,
    output logic               fastEntered
);
    logic [2:0] ackWait_reg;

    // one ack per request; count saturates
    always_ff @(posedge core_clk) begin
        if (reset || !coreReq.request) begin
            ackWait_reg <= 3'h0;
        end else if (ackWait_reg != 3'h7) begin
            ackWait_reg <= ackWait_reg + 3'h1;
        end
        coreIrqAck <= coreReq.request && (ackWait_reg == (slowAck ? 3'h5 : 3'h0));
    end
    // fast entry unless fetch is a subroutine jump
    always_ff @(posedge core_clk) begin
        fastEntered <= !reset && coreReq.fast && FETCH_WORD != SUBR_JUMP_OP;
    end
endmodule : ivp_core_model

// file: tb/testbench.sv
// self-checking bench for the vectoring unit
`timescale 1ns/1ps
`include "ivp_params.svh"
module testbench;
    import ivp_pkg::*;
    logic          core_clk, reset, avs_read, avs_write, avs_waitrequest, coreIrqAck;
    logic          lowPowerMode, coreAddrDrive, wakeRequest, slowAck;
    logic [7:0]    avs_address;
    logic [31:0]   avs_writedata, avs_readdata, rngState, rd, v;
    logic [1:0]    coreStatusMask;
    logic [81:0]   periphIrq, irqNext;
    logic [15:0]   pword [10];
    logic [15:0]   vbase, fvl [2];
    logic [6:0]    fm [2];
    logic [4:0]    fvh [2];
    ivp_core_req_s coreReq;
    int            fails, samplesChecked, w;

    ivp_irq_arbiter ivp_irq_arbiter_inst (.core_clk(core_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .periphIrq(periphIrq), .externalIrqA_n(1'b1),
        .externalIrqB_n(1'b1), .coreStatusMask(coreStatusMask), .coreIrqAck(coreIrqAck),
        .lowPowerMode(lowPowerMode), .coreReq(coreReq), .coreAddrDrive(coreAddrDrive),
        .wakeRequest(wakeRequest));
    ivp_core_model ivp_core_model_inst (.core_clk(core_clk), .reset(reset), .coreReq(coreReq),
        .slowAck(slowAck), .coreIrqAck(coreIrqAck), .fastEntered());

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    function automatic logic [31:0] rnd();
        rngState = rngState ^ (rngState << 13);
        rngState = rngState ^ (rngState >> 17);
        rngState = rngState ^ (rngState << 5);
        return rngState;
    endfunction : rnd
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val
    task automatic check_core(input ivp_core_req_s exp, input ivp_core_req_s got);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED coreReq expected %h seen %h", exp, got);
        end
    endtask : check_core
    // request held until waitrequest is low at a rising edge
    task automatic bus(input logic wr, input int idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= 8'(idx * 4);
        {avs_write, avs_read} <= {wr, !wr};
        avs_writedata <= {16'h0000, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) fails++;
        rd = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask : bus
    // reference: highest permitted level, lowest source
    function automatic ivp_core_req_s expect_core();
        ivp_core_req_s r;
        logic [1:0] p;
        int ch;
        r = '0;
        for (int lvl = 3; lvl >= 0; lvl--) begin
            for (int s = 0; s < `IVP_NUM_SRC; s++) begin
                p = (s < 2) ? 2'h3 : pword[(s - 2) / 8][2 * ((s - 2) % 8) +: 2];
                if (!r.request && periphIrq[s] && p == lvl
                    && (coreStatusMask == 2'h0 || lvl >= coreStatusMask)) begin
                    r.request = 1'b1;
                    r.levelCode = (lvl >= 2) ? 2'h3 : 2'(lvl + 1);
                    r.vecNum = 7'(s);
                    ch = (fm[0] == s) ? 0 : ((fm[1] == s) ? 1 : 0);
                    r.fast = (lvl == 2) && (fm[0] == s || fm[1] == s);
                    r.vecAddr = r.fast ? {fvh[ch], fvl[ch]} : {vbase[13:0], 7'(s)};
                end
            end
        end
        return r;
    endfunction : expect_core
    task automatic report_and_stop();
        if (fails == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #4000000;
        fails++;
        report_and_stop();
    end
    initial begin
        {avs_read, avs_write, lowPowerMode, slowAck} = 4'h0;
        {avs_address, avs_writedata, periphIrq, coreStatusMask} = '0;
        {fails, samplesChecked} = 0;
        rngState = 32'h6d04;
        reset = 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        for (w = 0; w < 6; w++) bus(1'b1, `IVP_IDX_EN_FIRST + w, 16'hffff);
        bus(1'b0, 8'h20, 16'h0);
        check_val("unmapped", 32'h0, rd);
        for (int it = 0; it < 40; it++) begin
            for (w = 0; w < 10; w++) begin
                v = rnd();
                pword[w] = v[15:0];
                bus(1'b1, w, v[15:0]);
            end
            v = rnd();
            vbase = v[15:0];
            bus(1'b1, `IVP_IDX_VBASE, vbase);
            for (int c = 0; c < 2; c++) begin
                v = rnd();
                fm[c] = 7'(4 + v % 78);
                fvl[c] = v[31:16];
                fvh[c] = v[4:0];
                bus(1'b1, `IVP_IDX_FM0 + 3 * c, {9'h0, fm[c]});
                bus(1'b1, `IVP_IDX_FVL0 + 3 * c, fvl[c]);
                bus(1'b1, `IVP_IDX_FVH0 + 3 * c, {11'h0, fvh[c]});
            end
            for (int s = 0; s < `IVP_NUM_SRC; s++) begin
                v = rnd();
                irqNext[s] = (v[4:0] == 5'h0) || ((s == fm[0] || s == fm[1]) && v[5]);
            end
            irqNext[3:2] = 2'b00;
            v = rnd();
            periphIrq <= irqNext;
            coreStatusMask <= v[1:0];
            slowAck <= v[2];
            repeat (3) @(posedge core_clk);
            #1 check_core(expect_core(), coreReq);
            w = v[10:3] % 10;
            bus(1'b0, w, 16'h0);
            check_val("priority", {16'h0, pword[w]}, rd);
            w = v[18:11] % 6;
            bus(1'b1, `IVP_IDX_PEND_FIRST + w, v[31:16]);
            bus(1'b0, `IVP_IDX_PEND_FIRST + w, 16'h0);
            check_val("pending", {16'h0, 16'({14'h0, periphIrq} >> (16 * w))}, rd);
        end
        // low power: 16 disabled before entry, 17 enabled
        periphIrq <= '0;
        bus(1'b1, `IVP_IDX_EN_FIRST + 1, 16'hfffe);
        lowPowerMode <= 1'b1;
        repeat (3) @(posedge core_clk);
        periphIrq[16] <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 check_val("wake", 32'h0, {31'h0, wakeRequest});
        @(posedge core_clk);
        periphIrq[17] <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 check_val("wake", 32'h1, {31'h0, wakeRequest});
        report_and_stop();
    end
endmodule : testbench
